// ===== rtl/css_pkg.sv
// Package for the shutter signal block: field layouts, trigger bits, select codes.
// Assumes the timing core supplies field, line and pixel counts on the block clock.
package css_pkg;

  localparam int TRIG_W = 8;
  localparam int TRIG_EXPOSURE = 6;
  localparam int TRIG_READOUT = 7;
  localparam int TRIG_BIAS0 = 4;
  localparam int NUM_SHUT = 4;
  localparam int NUM_BIAS = 2;
  localparam int SEL_W = 3;
  localparam int LINE_W = 12;
  localparam int PIX_W = 13;
  localparam int FLD_W = 12;
  localparam logic [SEL_W-1:0] SEL_BIAS0_MUX = 3'h4;
  localparam logic [SEL_W-1:0] SEL_BIAS1_MUX = 3'h5;
  localparam logic [SEL_W-1:0] SEL_INVALID = 3'h6;
  localparam logic [SEL_W-1:0] SEL_SHUT12_MUX = 3'h7;
  localparam logic [PIX_W-1:0] BIAS_ON_PIXEL = 13'h0000;
  localparam logic RST_LEVEL = 1'b0;

  typedef struct packed {
    logic vd_edge;
    logic hd_edge;
    logic [LINE_W-1:0] line;
    logic [PIX_W-1:0] pixel;
    logic [FLD_W-1:0] expo_field;
    logic last_substrate_clock_field;
    logic readout_start;
    logic readout_end;
  } css_timing_t;

  typedef struct packed {
    logic shutter_manual_enable;
    logic shutter_manual_level;
    logic shutter_active_polarity;
    logic [FLD_W-1:0] shutter_on_field;
    logic [LINE_W-1:0] shutter_on_line;
    logic [PIX_W-1:0] shutter_on_pixel;
    logic [FLD_W-1:0] shutter_off_field;
    logic [LINE_W-1:0] shutter_off_line;
    logic [PIX_W-1:0] shutter_off_pixel;
  } css_shut_cfg_t;

  typedef struct packed {
    logic bias_mode_select;
    logic bias_keep_active;
    logic [LINE_W-1:0] bias_on_line;
    logic bias_start_polarity;
  } css_bias_cfg_t;

  typedef struct packed {
    logic [SEL_W-1:0] bias_pin_source_select;
    logic [SEL_W-1:0] mech_shutter_pin_source_select;
    logic [SEL_W-1:0] strobe_pin_source_select;
    logic [SEL_W-1:0] test_output_source_select;
    logic bias0_combiner_select;
    logic bias1_combiner_select;
    logic shutter12_combiner_select;
  } css_route_cfg_t;

endpackage

// ===== rtl/css_pin_sel.sv
// One output pin source selector with a registered output.
// Assumes the eight candidate sources are already at their pin polarity.
`timescale 1ns/1ns
`default_nettype none
module css_pin_sel (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] src,
  input wire logic [css_pkg::SEL_W-1:0] sel,
  output logic pin
);
  typedef struct packed {
    logic pin;
  } css_sel_state_t;

  css_sel_state_t st_ff;
  css_sel_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // The reserved code drives a quiet low rather than an arbitrary source
    if (sel == css_pkg::SEL_INVALID) begin
      nxt_st.pin = css_pkg::RST_LEVEL;
    end else begin
      nxt_st.pin = src[sel];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin = st_ff.pin;
endmodule
`default_nettype wire

// ===== rtl/css_bias_chan.sv
// One substrate-bias pulse channel: arming, mode 0/1 start, keep-on release.
// Assumes readout start and end arrive as one-cycle pulses from the sequencer.
`timescale 1ns/1ns
`default_nettype none
module css_bias_chan (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire css_pkg::css_timing_t tm,
  input wire css_pkg::css_bias_cfg_t cfg,
  input wire logic arm,
  output logic active,
  output logic level
);
  typedef struct packed {
    logic armed;
    logic active;
    logic done;
    logic level;
  } css_bias_state_t;

  css_bias_state_t st_ff;
  css_bias_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (arm) begin
      nxt_st.armed = 1'b1;
      nxt_st.done = 1'b0;
    end
    if (st_ff.armed) begin
      if (!cfg.bias_mode_select) begin
        // Mode 0 starts in the field of the last substrate clock
        if (tm.last_substrate_clock_field && tm.line == cfg.bias_on_line &&
            tm.pixel == css_pkg::BIAS_ON_PIXEL) begin
          nxt_st.active = 1'b1;
        end
      end else if (tm.readout_start) begin
        nxt_st.active = 1'b1;
      end
      // A fresh arm in the same cycle as readout end wins, so the new trigger is not lost
      if (tm.readout_end && !arm) begin
        nxt_st.armed = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
    // Keep-on holds the pulse past readout until software drops the bit
    if (st_ff.done && !cfg.bias_keep_active) begin
      nxt_st.active = 1'b0;
      nxt_st.done = 1'b0;
    end
    // Start polarity gives the pin level while the pulse is on
    nxt_st.level = nxt_st.active ? cfg.bias_start_polarity : ~cfg.bias_start_polarity;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign active = st_ff.active;
  assign level = st_ff.level;
endmodule
`default_nettype wire

// ===== rtl/css_shutter_ctrl.sv
// Shutter signal control top: four shutter pulses, two bias pulses, combiners
// and the four output pin selectors.
// Assumes vertical_sync and horizontal_sync edges arrive as one-cycle pulses, with
// line, pixel and exposure field counts valid on the same clock.
//
// Overview of operation
// - Trigger without exposure bit puts on and off toggles in next field, fields ignored.
// - With exposure also triggered, shutter pulses follow automatic field matching instead.
// - Manual control uses only the on or off position, picked by manual level.
// - Manual control ignores the on-field and off-field values.
// - Manual control works regardless of any triggered exposure.
// - A pulse left on by manual control stays on until a later off toggle.
// - Trigger on an already active pulse skips on toggle, does only off.
// - Internal trigger signals stay asserted through the whole line after a write.
// - Bias pin selector: 0-3 shutters, 4 bias0 mix, 5 bias1 mix, 6 invalid, 7 shut mix.
// - Mechanical-shutter pin has its own selector with the same coding.
// - Strobe pin has its own selector with the same coding.
// - Internal test output has its own selector with the same coding.
// - Bias0 mix gives bias0, or shutter0 AND bias0 when selected.
// - Bias1 mix gives bias1, or shutter0 AND bias1 when selected.
// - Shutter mix gives shutter0 AND shutter1, or shutter0 AND shutter2.
// - Each bias pulse has a one-bit mode select between mode 0 and mode 1.
// - Mode 0 starts at programmed line of last substrate clock field; mode 1 at readout.
// - Keep-on holds a bias pulse active after readout until software clears it.
// - Each bias pulse has a 12-bit on line within the field.
// - Each bias pulse has a start polarity for its triggered level.
// - Each shutter pulse has manual enable and manual level bits.
// - On and off toggles each use 12-bit field, 12-bit line, 13-bit pixel.
// - Automatic toggles match field against exposure field counter, then line and pixel.
// - Trigger bits: 0-3 shutters, 4-5 bias pulses, 6 exposure, 7 readout.
`timescale 1ns/1ns
`default_nettype none
module css_shutter_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire css_pkg::css_timing_t tm,
  input wire logic trig_wr,
  input wire logic [css_pkg::TRIG_W-1:0] trig_data,
  input wire css_pkg::css_shut_cfg_t [css_pkg::NUM_SHUT-1:0] shut_cfg,
  input wire css_pkg::css_bias_cfg_t [css_pkg::NUM_BIAS-1:0] bias_cfg,
  input wire css_pkg::css_route_cfg_t route_cfg,
  output logic substrate_bias_pin,
  output logic mechanical_shutter_pin,
  output logic strobe_pin,
  output logic internal_test_output,
  output logic [css_pkg::NUM_SHUT-1:0] shutter_active,
  output logic [css_pkg::NUM_BIAS-1:0] bias_active,
  output logic exposure_triggered,
  output logic readout_triggered,
  output logic trigger_hold
);
  localparam int NS = css_pkg::NUM_SHUT;

  typedef struct packed {
    logic hold;
    logic line_seen;
    logic [css_pkg::TRIG_W-1:0] trig;
    logic expo;
    logic readout;
    logic [NS-1:0] arm_ok;
    logic [NS-1:0] active;
    logic [NS-1:0] on_pend;
    logic [NS-1:0] off_pend;
    logic [NS-1:0] single;
    logic [NS-1:0] in_fld;
    logic [NS-1:0] man_used;
    logic [NS-1:0] level;
  } css_top_state_t;

  css_top_state_t st_ff;
  css_top_state_t nxt_st;

  logic [NS-1:0] trig_sig;
  logic [css_pkg::NUM_BIAS-1:0] bias_arm;
  logic [css_pkg::NUM_BIAS-1:0] bias_level;
  logic mix_bias0;
  logic mix_bias1;
  logic mix_shut12;
  logic [7:0] pin_src;

  // Internal trigger signal per shutter pulse, stretched by the hold window
  assign trig_sig = st_ff.hold ? st_ff.trig[NS-1:0] : '0;

  always_comb begin
    logic on_hit;
    logic off_hit;
    logic fld_on;
    logic fld_off;
    logic expo_now;
    on_hit = 1'b0;
    off_hit = 1'b0;
    fld_on = 1'b0;
    fld_off = 1'b0;
    expo_now = 1'b0;
    nxt_st = st_ff;

    // A write latches the trigger bits; they stay up until the end of the
    // following line so late toggle positions are not lost
    if (trig_wr) begin
      nxt_st.trig = trig_data;
      nxt_st.hold = 1'b1;
      nxt_st.line_seen = 1'b0;
      nxt_st.arm_ok = '1;
    end else if (st_ff.hold && tm.hd_edge) begin
      if (!st_ff.line_seen) begin
        nxt_st.line_seen = 1'b1;
      end else begin
        nxt_st.hold = 1'b0;
      end
    end

    // Exposure and readout operation flags
    if (trig_wr && trig_data[css_pkg::TRIG_EXPOSURE]) begin
      nxt_st.expo = 1'b1;
    end else if (tm.readout_start) begin
      nxt_st.expo = 1'b0;
    end
    if (trig_wr && trig_data[css_pkg::TRIG_READOUT]) begin
      nxt_st.readout = 1'b1;
    end else if (tm.readout_end) begin
      nxt_st.readout = 1'b0;
    end
    expo_now = st_ff.expo || (st_ff.hold && st_ff.trig[css_pkg::TRIG_EXPOSURE]);

    for (int i = 0; i < NS; i++) begin
      // Arm once per write while the internal trigger is up
      if (trig_sig[i] && st_ff.arm_ok[i] && !trig_wr) begin
        nxt_st.arm_ok[i] = 1'b0;
        // An already active pulse only gets its off toggle
        nxt_st.on_pend[i] = !st_ff.active[i];
        nxt_st.off_pend[i] = 1'b1;
        // Without exposure the pulse is single-shot in the next field
        // but an exposure trigger forces automatic timing
        nxt_st.single[i] = !expo_now;
        nxt_st.in_fld[i] = 1'b0;
      end

      // Single trigger: the next field opens the window, the one after closes it
      if (st_ff.single[i] && (st_ff.on_pend[i] || st_ff.off_pend[i]) && tm.vd_edge) begin
        if (!st_ff.in_fld[i]) begin
          nxt_st.in_fld[i] = 1'b1;
        end else begin
          nxt_st.on_pend[i] = 1'b0;
          nxt_st.off_pend[i] = 1'b0;
          nxt_st.in_fld[i] = 1'b0;
        end
      end

      // Field gate: single ignores field values, automatic uses exposure count
      fld_on = st_ff.single[i] ? st_ff.in_fld[i] :
               (tm.expo_field == shut_cfg[i].shutter_on_field);
      fld_off = st_ff.single[i] ? st_ff.in_fld[i] :
                (tm.expo_field == shut_cfg[i].shutter_off_field);
      on_hit = tm.line == shut_cfg[i].shutter_on_line &&
               tm.pixel == shut_cfg[i].shutter_on_pixel;
      off_hit = tm.line == shut_cfg[i].shutter_off_line &&
                tm.pixel == shut_cfg[i].shutter_off_pixel;

      if (tm.vd_edge) begin
        nxt_st.man_used[i] = 1'b0;
      end

      if (shut_cfg[i].shutter_manual_enable) begin
        // Manual mode ignores field values and any exposure state
        // only one toggle is honoured per interval
        if (!st_ff.man_used[i] && !tm.vd_edge) begin
          if (shut_cfg[i].shutter_manual_level && on_hit) begin
            nxt_st.active[i] = 1'b1;
            nxt_st.man_used[i] = 1'b1;
          end else if (!shut_cfg[i].shutter_manual_level && off_hit) begin
            nxt_st.active[i] = 1'b0;
            nxt_st.man_used[i] = 1'b1;
          end
        end
      end else begin
        // Leaving manual mode keeps the level until a later off toggle
        if (st_ff.on_pend[i] && fld_on && on_hit) begin
          nxt_st.active[i] = 1'b1;
          nxt_st.on_pend[i] = 1'b0;
        end else if (st_ff.off_pend[i] && !st_ff.on_pend[i] && fld_off && off_hit) begin
          nxt_st.active[i] = 1'b0;
          nxt_st.off_pend[i] = 1'b0;
          nxt_st.single[i] = 1'b0;
          nxt_st.in_fld[i] = 1'b0;
        end
      end

      // Active polarity applied ahead of the selectors
      nxt_st.level[i] = shut_cfg[i].shutter_active_polarity ?
                        nxt_st.active[i] : ~nxt_st.active[i];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bias pulses arm from their trigger bits on the write itself
  assign bias_arm = trig_wr ? trig_data[css_pkg::TRIG_BIAS0 +: css_pkg::NUM_BIAS] : '0;

  for (genvar b = 0; b < css_pkg::NUM_BIAS; b++) begin : g_bias
    css_bias_chan u_bias (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .tm(tm),
      .cfg(bias_cfg[b]),
      .arm(bias_arm[b]),
      .active(bias_active[b]),
      .level(bias_level[b])
    );
  end

  // Combiners work on pin-level signals, so polarity is already folded in
  assign mix_bias0 = route_cfg.bias0_combiner_select ?
                     (st_ff.level[0] & bias_level[0]) : bias_level[0];
  assign mix_bias1 = route_cfg.bias1_combiner_select ?
                     (st_ff.level[0] & bias_level[1]) : bias_level[1];
  assign mix_shut12 = route_cfg.shutter12_combiner_select ?
                      (st_ff.level[0] & st_ff.level[2]) :
                      (st_ff.level[0] & st_ff.level[1]);

  // Source index follows the selector coding; slot 6 is never chosen
  assign pin_src = {mix_shut12, css_pkg::RST_LEVEL, mix_bias1, mix_bias0, st_ff.level};

  css_pin_sel u_sel_bias (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src(pin_src),
    .sel(route_cfg.bias_pin_source_select),
    .pin(substrate_bias_pin)
  );

  css_pin_sel u_sel_mech (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src(pin_src),
    .sel(route_cfg.mech_shutter_pin_source_select),
    .pin(mechanical_shutter_pin)
  );

  css_pin_sel u_sel_strobe (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src(pin_src),
    .sel(route_cfg.strobe_pin_source_select),
    .pin(strobe_pin)
  );

  css_pin_sel u_sel_test (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src(pin_src),
    .sel(route_cfg.test_output_source_select),
    .pin(internal_test_output)
  );

  assign shutter_active = st_ff.active;
  assign exposure_triggered = st_ff.expo;
  assign readout_triggered = st_ff.readout;
  assign trigger_hold = st_ff.hold;
endmodule
`default_nettype wire

// ===== bench/css_shutter_ctrl_chk.sv
// Port checker for the shutter signal block.
// Assumes a bind onto the top module; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module css_shutter_ctrl_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire css_pkg::css_timing_t tm,
  input wire logic trig_wr,
  input wire logic [css_pkg::TRIG_W-1:0] trig_data,
  input wire css_pkg::css_shut_cfg_t [css_pkg::NUM_SHUT-1:0] shut_cfg,
  input wire css_pkg::css_bias_cfg_t [css_pkg::NUM_BIAS-1:0] bias_cfg,
  input wire css_pkg::css_route_cfg_t route_cfg,
  input wire logic substrate_bias_pin,
  input wire logic mechanical_shutter_pin,
  input wire logic strobe_pin,
  input wire logic internal_test_output,
  input wire logic [css_pkg::NUM_SHUT-1:0] shutter_active,
  input wire logic [css_pkg::NUM_BIAS-1:0] bias_active,
  input wire logic exposure_triggered,
  input wire logic readout_triggered,
  input wire logic trigger_hold
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  hold_rise_a: assert property (trig_wr |=> trigger_hold)
    else $error("trigger window not opened");
  hold_end_a: assert property ($fell(trigger_hold) && $past(nrst)
    |-> $past(tm.hd_edge) || $past(tm.hd_edge, 2)) else $error("window closed mid line");
  expo_set_a: assert property (trig_wr && trig_data[css_pkg::TRIG_EXPOSURE]
    && !tm.readout_start |=> exposure_triggered) else $error("exposure flag not set");
  read_set_a: assert property (trig_wr && trig_data[css_pkg::TRIG_READOUT]
    && !tm.readout_end |=> readout_triggered) else $error("readout flag not set");
  expo_clr_a: assert property (tm.readout_start && !trig_wr |=> !exposure_triggered)
    else $error("exposure flag kept");
  bias_inv_a: assert property (route_cfg.bias_pin_source_select == css_pkg::SEL_INVALID
    |=> !substrate_bias_pin) else $error("invalid select drives pin");
  // Four stable samples cover the level flop and the pin flop behind it
  strobe_src_a: assert property ((route_cfg.strobe_pin_source_select == 3'h0
    && $stable(shutter_active[0]) && $stable(shut_cfg[0].shutter_active_polarity)) [*4]
    |-> strobe_pin == (shutter_active[0] ~^ shut_cfg[0].shutter_active_polarity))
    else $error("strobe pin source wrong");
  bias_mix_a: assert property ((route_cfg.mech_shutter_pin_source_select == 3'h4
    && !route_cfg.bias0_combiner_select && $stable(bias_active[0])
    && $stable(bias_cfg[0].bias_start_polarity)) [*4]
    |-> mechanical_shutter_pin == (bias_active[0] ~^ bias_cfg[0].bias_start_polarity))
    else $error("bias mix source wrong");
  cover property (trig_wr && trig_data[css_pkg::TRIG_EXPOSURE]);
  cover property ($rose(shutter_active[1]));
  cover property ($fell(bias_active[0]));
endmodule
`default_nettype wire

// ===== bench/css_far_end.sv
// Far-side model: shutter, strobe and bias hardware seen as rising-edge counters.
// Assumes push-pull pin levels, sampled on the block clock.
`timescale 1ns/1ns
`default_nettype none
module css_far_end (
  input wire logic sys_clk,
  input wire logic [3:0] pins,
  output logic [3:0][7:0] rises
);
  logic [3:0] last_ff = 4'h0;
  logic [3:0][7:0] cnt_ff = '0;
  assign rises = cnt_ff;
  // Counting edges, not levels, catches glitches that a level check would miss
  always @(posedge sys_clk) begin
    last_ff <= pins;
    for (int i = 0; i < 4; i++) begin
      if (pins[i] && !last_ff[i]) begin
        cnt_ff[i] <= cnt_ff[i] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/css_shutter_ctrl_tb.sv
// Bench for the shutter signal block: route table, trigger, manual, bias and reset cases.
// Assumes a 16-pixel, 8-line field made here and the far-end edge counter.
`timescale 1ns/1ns
`default_nettype none
module css_shutter_ctrl_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic trig_wr = 1'b0;
  logic rs = 1'b0;
  logic re = 1'b0;
  logic lsf = 1'b0;
  logic [7:0] trig_data = 8'h00;
  int pix = 0;
  int ln = 0;
  int fld = 0;
  int error_cnt = 0;
  int checked = 0;
  css_pkg::css_timing_t tm;
  css_pkg::css_shut_cfg_t [3:0] sc = '0;
  css_pkg::css_bias_cfg_t [1:0] bc = '0;
  css_pkg::css_route_cfg_t rc = '0;
  wire logic [3:0] pins;
  logic [3:0] sa;
  logic [1:0] ba;
  logic et, rt, th;
  logic [3:0][7:0] rises;
  logic [7:0] c0;
  // Selects b/m/s/t, combiner bits, shutter and bias polarity, then pins b/m/s/t
  logic [24:0] rows [13] = '{
    {12'h053, 3'h0, 4'h5, 2'h0, 4'h5}, {12'h688, 3'h0, 4'h5, 2'h0, 4'ha},
    {12'h924, 3'h0, 4'hf, 2'h0, 4'hf}, {12'h924, 3'h4, 4'hf, 2'h0, 4'h0},
    {12'h924, 3'h4, 4'he, 2'h0, 4'hf}, {12'hb6d, 3'h0, 4'hf, 2'h2, 4'h0},
    {12'hb6d, 3'h0, 4'hf, 2'h1, 4'hf}, {12'hb6d, 3'h2, 4'hf, 2'h1, 4'h0},
    {12'hb6d, 3'h2, 4'he, 2'h1, 4'hf}, {12'hdb6, 3'h0, 4'h0, 2'h0, 4'h0},
    {12'hfff, 3'h0, 4'hc, 2'h0, 4'hf}, {12'hfff, 3'h1, 4'hc, 2'h0, 4'h0},
    {12'hfff, 3'h1, 4'ha, 2'h0, 4'hf}};

  css_shutter_ctrl dut (
    .sys_clk(sys_clk), .nrst(nrst), .tm(tm), .trig_wr(trig_wr), .trig_data(trig_data),
    .shut_cfg(sc), .bias_cfg(bc), .route_cfg(rc), .substrate_bias_pin(pins[3]),
    .mechanical_shutter_pin(pins[2]), .strobe_pin(pins[1]), .internal_test_output(pins[0]),
    .shutter_active(sa), .bias_active(ba), .exposure_triggered(et),
    .readout_triggered(rt), .trigger_hold(th));
  css_far_end far (.sys_clk(sys_clk), .pins(pins), .rises(rises));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    pix <= (pix + 1) % 16;
    if (pix == 15) begin
      ln <= (ln + 1) % 8;
    end
    if (pix == 15 && ln == 7) begin
      fld <= fld + 1;
    end
  end
  always_comb begin
    tm.vd_edge = pix == 0 && ln == 0;
    tm.hd_edge = pix == 0;
    tm.line = 12'(ln);
    tm.pixel = 13'(pix);
    tm.expo_field = 12'(fld);
    tm.last_substrate_clock_field = lsf;
    tm.readout_start = rs;
    tm.readout_end = re;
  end

  task report_and_stop();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Waits nf field starts, then to pixel 8 of line l; bounded so a stall ends the run
  task automatic go(input int nf, input int l);
    int t;
    int n;
    t = fld + nf;
    n = 0;
    while (!(fld == t && ln == l && pix == 8) && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 3000) begin
      error_cnt++;
      report_and_stop();
    end else begin
      #1;
    end
  endtask
  task wr(input logic [7:0] d);
    @(posedge sys_clk);
    trig_wr <= 1'b1;
    trig_data <= d;
    @(posedge sys_clk);
    trig_wr <= 1'b0;
  endtask
  task pulse(input logic s);
    @(posedge sys_clk);
    rs <= s;
    re <= !s;
    @(posedge sys_clk);
    rs <= 1'b0;
    re <= 1'b0;
  endtask
  task setsh(input int i, input logic m, input logic lv, input logic [11:0] fd,
             input logic [11:0] onl, input logic [11:0] offl);
    @(posedge sys_clk);
    sc[i] <= '{m, lv, 1'b1, fd, onl, 13'h0005, fd, offl, 13'h0005};
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    go(1, 1);
    for (int r = 0; r < 13; r++) begin
      @(posedge sys_clk);
      rc <= rows[r][24:10];
      for (int i = 0; i < 4; i++) begin
        sc[i].shutter_active_polarity <= rows[r][6 + i];
      end
      bc[1].bias_start_polarity <= rows[r][5];
      bc[0].bias_start_polarity <= rows[r][4];
      repeat (5) @(posedge sys_clk);
      #1;
      chk(8'(pins), 8'(rows[r][3:0]));
    end
    $display("routing table done");
    @(posedge sys_clk);
    rc <= '{3'h4, 3'h1, 3'h0, 3'h3, 1'b0, 1'b0, 1'b0};
    bc[0] <= '{1'b0, 1'b0, 12'h003, 1'b1};
    lsf <= 1'b1;
    setsh(0, 1'b0, 1'b0, 12'h007, 12'h002, 12'h004);
    go(1, 1);
    c0 = rises[1];
    wr(8'h01);
    go(0, 2);
    chk(8'(th), 8'h01);
    go(0, 3);
    chk(8'(sa), 8'h00);
    go(1, 3);
    chk(8'(sa[0]), 8'h01);
    go(0, 6);
    chk(8'(sa[0]), 8'h00);
    chk(rises[1] - c0, 8'h01);
    go(1, 3);
    chk(8'(sa[0]), 8'h00);
    $display("single trigger done");
    go(1, 1);
    setsh(0, 1'b0, 1'b0, 12'(fld + 2), 12'h002, 12'h004);
    wr(8'h41);
    go(1, 3);
    chk(8'(sa[0]), 8'h00);
    chk(8'(et), 8'h01);
    go(1, 3);
    chk(8'(sa[0]), 8'h01);
    go(0, 6);
    chk(8'(sa[0]), 8'h00);
    pulse(1'b1);
    $display("automatic trigger done");
    wr(8'h40);
    setsh(1, 1'b1, 1'b1, 12'h009, 12'h002, 12'h004);
    go(1, 3);
    chk(8'(sa[1]), 8'h01);
    go(0, 6);
    chk(8'(sa[1]), 8'h01);
    pulse(1'b1);
    setsh(1, 1'b0, 1'b1, 12'h009, 12'h005, 12'h004);
    go(1, 3);
    chk(8'(sa[1]), 8'h01);
    wr(8'h02);
    go(1, 3);
    chk(8'(sa[1]), 8'h01);
    go(0, 6);
    chk(8'(sa[1]), 8'h00);
    $display("manual control done");
    go(1, 1);
    wr(8'h10);
    go(0, 5);
    chk(8'(ba[0]), 8'h01);
    chk(8'(pins[3]), 8'h01);
    pulse(1'b0);
    go(0, 7);
    chk(8'(ba[0]), 8'h00);
    @(posedge sys_clk);
    bc[0] <= '{1'b1, 1'b1, 12'h003, 1'b1};
    go(1, 1);
    wr(8'h90);
    go(0, 5);
    chk(8'(ba[0]), 8'h00);
    chk(8'(rt), 8'h01);
    pulse(1'b1);
    go(0, 7);
    chk(8'(ba[0]), 8'h01);
    pulse(1'b0);
    go(1, 2);
    chk(8'(ba[0]), 8'h01);
    @(posedge sys_clk);
    bc[0].bias_keep_active <= 1'b0;
    go(0, 4);
    chk(8'(ba[0]), 8'h00);
    $display("bias pulse done");
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    go(1, 3);
    chk({sa, ba, et, rt}, 8'h00);
    chk(8'(pins[1]), 8'h00);
    $display("reset done");
    report_and_stop();
  end
endmodule
bind css_shutter_ctrl css_shutter_ctrl_chk chk (.sys_clk, .nrst, .tm, .trig_wr, .trig_data,
  .shut_cfg, .bias_cfg, .route_cfg, .substrate_bias_pin, .mechanical_shutter_pin,
  .strobe_pin, .internal_test_output, .shutter_active, .bias_active,
  .exposure_triggered, .readout_triggered, .trigger_hold);
`default_nettype wire
